// ===== verilog/rwc_params.svh
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH

`define RWC_CLK_MHZ     100
// Register byte offsets
`define RWC_ADR_WDT     8'h00
`define RWC_ADR_CAUSE   8'h04
`define RWC_ADR_MISC    8'h08
// Watchdog control fields
`define RWC_CTL_CHG     4
`define RWC_CTL_EN      3
// Reset cause flag positions
`define RWC_F_POR       0
`define RWC_F_PIN       1
`define RWC_F_BO        2
`define RWC_F_WD        3
`define RWC_F_TAP       4
// Misc register fields
`define RWC_M_COMPARATOR_REFERENCE_SELECT      0
`define RWC_M_ADC       1
// Watchdog base count, 16K oscillator cycles
`define RWC_WDT_BASE    22'h00_4000
`define RWC_CHG_WIN     4
`define RWC_BOD_MIN_NS  2000
`define RWC_BOD_MIN_CYC ((`RWC_BOD_MIN_NS * `RWC_CLK_MHZ + 999) / 1000)
// Sync reset values: pin idles high
`define RWC_SYNC_RST    7'h01

`endif

// ===== verilog/rwc_pkg.sv
package rwc_pkg;

    typedef struct packed {
        logic       watchdog_change_enable_bit;
        logic       watchdog_enable_bit;
        logic [2:0] watchdog_prescale_field;
    } rwc_wdt_ctrl_t;

    typedef struct packed {
        logic test_port_reset_flag;
        logic watchdog_reset_flag;
        logic brownout_reset_flag;
        logic pin_reset_flag;
        logic power_on_reset_flag;
    } rwc_cause_t;

    typedef struct packed {
        logic bod_en;
        logic always_on;
        logic osc;
        logic tap;
        logic bod_low;
        logic por;
        logic ext_n;
    } rwc_pins_t;

endpackage

// ===== verilog/rwc_reset_watchdog.sv
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "rwc_params.svh"

// How it works
// [RULE1] Five reset sources each drive the internal chip reset.
// [RULE2] Low external pin asserts reset asynchronously, without any clock.
// [RULE3] Pin release starts the delay counter; reset ends when it expires.
// [RULE4] Test-port reset bit at one holds the chip in reset.
// [RULE5] Power-on inactive starts delay; reactivation resets at once.
// [RULE6] Enabled brown-out resets at once; recovery releases after the delay.
// [RULE7] Low supply counts only after the minimum brown-out duration.
// [RULE8] Watchdog expiry gives a reset pulse of exactly one clock.
// [RULE9] Delay counter starts when the watchdog pulse ends.
// [RULE10] Reference on when brown-out enabled, comparator select set, or converter on.
// [RULE11] Watchdog counts ticks of its own 1 MHz oscillator.
// [RULE12] Restart, disable and chip reset clear the watchdog counter.
// [RULE13] Eight periods; expiry without restart resets the chip.
// [RULE14] Always-on config selects level 2; else level 1, initially disabled.
// [RULE15] Level 1: writing enable one turns the watchdog on anytime.
// [RULE16] Level 1: set change-enable and enable, then write new values within four.
// [RULE17] Level 2: watchdog always enabled, enable reads one.
// [RULE18] Level 2: same sequence changes period; written enable ignored.
// [RULE19] Change-enable clears itself four clocks after being set.
// [RULE20] Enable clears only while change-enable is one.
// [RULE21] Prescale 000 is 16K oscillator cycles, each code doubles to 2048K.
// [RULE22] Cause flags record reset source; power-on clears others; write zero clears.
// [RULE23] Reset held while any source or the delay counter is active.
// [RULE24] Oscillator ticks synchronised into clock domain; restarts and expiry never lost.
module rwc_reset_watchdog
    import rwc_pkg::*;
#(
    parameter logic [21:0] WDT_BASE = `RWC_WDT_BASE
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ext_rst_n_i,
    input  wire logic        por_i,
    input  wire logic        bod_low_i,
    input  wire logic        tap_rst_i,
    input  wire logic        wdt_osc_i,
    input  wire logic        wdt_always_on_i,
    input  wire logic        bod_enable_i,
    input  wire logic [15:0] timeout_cycles_i,
    input  wire logic        wdt_restart_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             chip_rst_o,
    output logic             wdt_expire_o,
    output logic             vref_on_o
);

    localparam logic [6:0]  SYNC_RST = `RWC_SYNC_RST;
    localparam logic [15:0] BOD_MIN  = 16'(`RWC_BOD_MIN_CYC);
    localparam logic [1:0]  WIN_LOAD = 2'(`RWC_CHG_WIN - 1);

    rwc_pins_t     raw;
    rwc_pins_t     stb;
    logic [6:0]    s1_q;
    logic [6:0]    s2_q;
    logic [6:0]    s3_q;
    logic [6:0]    stb_q;
    logic [15:0]   bod_cnt_q;
    logic          bo_act_q;
    rwc_wdt_ctrl_t ctl_q;
    rwc_wdt_ctrl_t wv;
    logic [1:0]    win_q;
    logic          osc_d_q;
    logic          tick;
    logic [21:0]   wcnt_q;
    logic [21:0]   limit;
    logic          wd_pulse_q;
    rwc_cause_t    cause_q;
    rwc_cause_t    src;
    logic [4:0]    keep;
    logic          src_any;
    logic [15:0]   dly_q;
    logic          chip_rst_q;
    logic          chip_rst_d;
    logic          async_n;
    logic [1:0]    misc_q;
    logic          vref_q;
    logic          ack_q;
    logic [31:0]   dat_q;
    logic          req;
    logic          wr;
    logic [7:0]    adr;

    assign raw = {bod_enable_i, wdt_always_on_i, wdt_osc_i, tap_rst_i,
                  bod_low_i, por_i, ext_rst_n_i};
    assign stb = stb_q;

    // Three-stage sync; a change counts once stages two and three agree
    generate
        for (genvar i = 0; i < 7; i++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_q[i]  <= SYNC_RST[i];
                    s2_q[i]  <= SYNC_RST[i];
                    s3_q[i]  <= SYNC_RST[i];
                    stb_q[i] <= SYNC_RST[i];
                end else begin
                    s1_q[i] <= raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        stb_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    // Brown-out dip filter
    always_ff @(posedge clk_i) begin
        if (rst_i || !(stb.bod_low && stb.bod_en)) begin
            bod_cnt_q <= 16'h0000;
            bo_act_q  <= 1'b0;
        end else if (bod_cnt_q < BOD_MIN) begin
            bod_cnt_q <= bod_cnt_q + 16'h0001; // [RULE7]
        end else begin
            bo_act_q <= 1'b1; // [RULE6]
        end
    end

    // Bus slave: one wait state, ack drops the cycle after
    assign adr = wb_adr_i[7:0];
    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    // Writes land at the ack edge, while the master still holds its data
    assign wr  = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
    assign wv  = wb_dat_i[4:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (adr)
                `RWC_ADR_WDT: begin
                    dat_q <= {27'h000_0000, ctl_q.watchdog_change_enable_bit,
                              ctl_q.watchdog_enable_bit | stb.always_on, // [RULE17]
                              ctl_q.watchdog_prescale_field};
                end
                `RWC_ADR_CAUSE: begin
                    dat_q <= {27'h000_0000, cause_q};
                end
                `RWC_ADR_MISC: begin
                    dat_q <= {30'h0000_0000, misc_q};
                end
                default: begin
                    dat_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Watchdog control with timed change window
    always_ff @(posedge clk_i) begin
        if (rst_i || chip_rst_q) begin
            ctl_q <= 5'h00;
            win_q <= 2'h0;
        end else if (wr && adr == `RWC_ADR_WDT
                     && wv.watchdog_change_enable_bit && wv.watchdog_enable_bit) begin
            ctl_q.watchdog_change_enable_bit <= 1'b1; // [RULE16] [RULE18]
            ctl_q.watchdog_enable_bit        <= 1'b1;
            win_q                            <= WIN_LOAD;
        end else if (wr && adr == `RWC_ADR_WDT && ctl_q.watchdog_change_enable_bit) begin
            ctl_q.watchdog_change_enable_bit <= 1'b0;
            ctl_q.watchdog_prescale_field    <= wv.watchdog_prescale_field; // [RULE13]
            // Level 2 ignores the written enable
            ctl_q.watchdog_enable_bit <= wv.watchdog_enable_bit | stb.always_on; // [RULE18] [RULE20]
        end else begin
            if ((wr && adr == `RWC_ADR_WDT && wv.watchdog_enable_bit) || stb.always_on) begin
                ctl_q.watchdog_enable_bit <= 1'b1; // [RULE14] [RULE15] [RULE17]
            end
            if (ctl_q.watchdog_change_enable_bit) begin
                if (win_q == 2'h0) begin
                    ctl_q.watchdog_change_enable_bit <= 1'b0; // [RULE19]
                end else begin
                    win_q <= win_q - 2'h1;
                end
            end
        end
    end

    // Oscillator edge taken from the stable stage, never the first flop
    assign tick  = stb.osc & ~osc_d_q; // [RULE11] [RULE24]
    assign limit = WDT_BASE << ctl_q.watchdog_prescale_field; // [RULE21]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_d_q <= 1'b0;
        end else begin
            osc_d_q <= stb.osc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || chip_rst_q || !ctl_q.watchdog_enable_bit || wdt_restart_i) begin
            wcnt_q     <= 22'h00_0000; // [RULE12]
            wd_pulse_q <= 1'b0;
        end else if (tick && wcnt_q == limit - 22'h00_0001) begin
            wcnt_q     <= 22'h00_0000;
            wd_pulse_q <= 1'b1; // [RULE8] [RULE13]
        end else begin
            if (tick) begin
                wcnt_q <= wcnt_q + 22'h00_0001;
            end
            wd_pulse_q <= 1'b0;
        end
    end

    // Reset sources and stretch
    assign src = '{test_port_reset_flag: stb.tap, // [RULE4]
                   watchdog_reset_flag:  wd_pulse_q,
                   brownout_reset_flag:  bo_act_q,
                   pin_reset_flag:       ~stb.ext_n,
                   power_on_reset_flag:  stb.por};
    assign src_any    = |src; // [RULE1]
    assign chip_rst_d = src_any | (dly_q != 16'h0000); // [RULE23]
    assign async_n    = ext_rst_n_i & ~por_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= 16'h0000;
        end else if (src_any) begin
            dly_q <= timeout_cycles_i; // [RULE3] [RULE5] [RULE6] [RULE9]
        end else if (dly_q != 16'h0000) begin
            dly_q <= dly_q - 16'h0001;
        end
    end

    // Pin and power-on reach reset with no clock running
    always_ff @(posedge clk_i or negedge async_n) begin
        if (!async_n) begin
            chip_rst_q <= 1'b1; // [RULE2] [RULE5]
        end else if (rst_i) begin
            chip_rst_q <= 1'b1;
        end else begin
            chip_rst_q <= chip_rst_d;
        end
    end

    // Cause flags; a new event wins over a software clear
    assign keep = (wr && adr == `RWC_ADR_CAUSE) ? wb_dat_i[4:0] : 5'h1f;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= 5'h00;
        end else if (src.power_on_reset_flag) begin
            cause_q <= 5'h01; // [RULE22]
        end else begin
            cause_q <= rwc_cause_t'((cause_q & keep) | src); // [RULE22]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || chip_rst_q) begin
            misc_q <= 2'h0;
        end else if (wr && adr == `RWC_ADR_MISC) begin
            misc_q <= wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vref_q <= 1'b0;
        end else begin
            vref_q <= stb.bod_en | misc_q[`RWC_M_COMPARATOR_REFERENCE_SELECT] | misc_q[`RWC_M_ADC]; // [RULE10]
        end
    end

    assign wb_dat_o     = dat_q;
    assign wb_ack_o     = ack_q;
    assign chip_rst_o   = chip_rst_q;
    assign wdt_expire_o = wd_pulse_q;
    assign vref_on_o    = vref_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    src_to_reset_a: assert property (src_any |=> chip_rst_q) // [RULE1]
        else $error("source active but chip reset low");
    pin_async_a: assert property ($past(!ext_rst_n_i) && !ext_rst_n_i |-> chip_rst_q) // [RULE2]
        else $error("pin low without chip reset");
    delay_load_a: assert property ($fell(src_any) |-> dly_q == $past(timeout_cycles_i)) // [RULE3]
        else $error("delay not loaded at source release");
    tap_hold_a: assert property (stb.tap |=> chip_rst_q) // [RULE4]
        else $error("test-port bit without reset");
    por_hold_a: assert property ($rose(stb.por) |=> chip_rst_q && cause_q == 5'h01) // [RULE5]
        else $error("power-on not resetting at once");
    bod_reset_a: assert property ($rose(bo_act_q) |-> $past(stb.bod_low, 2) ##1 chip_rst_q) // [RULE6]
        else $error("brown-out reset wrong");
    bod_filter_a: assert property (bo_act_q |-> bod_cnt_q == BOD_MIN && stb.bod_en) // [RULE7]
        else $error("brown-out taken before minimum duration");
    wd_pulse_a: assert property (wd_pulse_q |=> !wd_pulse_q) // [RULE8]
        else $error("watchdog pulse longer than one cycle");
    wd_delay_a: assert property (wd_pulse_q ##1 !src_any |-> dly_q == $past(timeout_cycles_i)) // [RULE9]
        else $error("delay not started after watchdog pulse");
    vref_follow_a: assert property (##1 vref_on_o == $past(stb.bod_en | (|misc_q))) // [RULE10]
        else $error("reference enable mismatch");
    restart_clear_a: assert property (wdt_restart_i |=> wcnt_q == 22'h00_0000) // [RULE12]
        else $error("restart did not clear counter");
    level2_on_a: assert property ($past(stb.always_on) && stb.always_on && !$past(chip_rst_q)
                                  |-> ctl_q.watchdog_enable_bit) // [RULE17]
        else $error("level 2 watchdog disabled");
    chg_window_a: assert property ($rose(ctl_q.watchdog_change_enable_bit)
                                   |-> ##4 !ctl_q.watchdog_change_enable_bit) // [RULE19]
        else $error("change window longer than four cycles");
    en_protect_a: assert property ($fell(ctl_q.watchdog_enable_bit) && !$past(chip_rst_q)
                                   |-> $past(ctl_q.watchdog_change_enable_bit)) // [RULE20]
        else $error("enable cleared outside window");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");
    en_set_a: assert property (wr && adr == `RWC_ADR_WDT && wv.watchdog_enable_bit && !chip_rst_q
                               |=> ctl_q.watchdog_enable_bit) // [RULE15]
        else $error("enable write did not turn watchdog on");
    wd_limit_a: assert property (wd_pulse_q |-> $past(tick && wcnt_q == limit - 22'h00_0001)) // [RULE21]
        else $error("watchdog expired off its period");
    bo_flag_a: assert property (bo_act_q && !stb.por |=> cause_q.brownout_reset_flag) // [RULE22]
        else $error("brown-out flag not recorded");
    stretch_a: assert property (dly_q != 16'h0000 |=> chip_rst_q) // [RULE23]
        else $error("chip reset released while delay running");

    wd_expire_c: cover property (wd_pulse_q ##1 chip_rst_q);
    bod_reset_c: cover property ($rose(bo_act_q));
    wdt_off_c: cover property ($fell(ctl_q.watchdog_enable_bit) && !$past(chip_rst_q));
    lvl2_change_c: cover property (stb.always_on && $fell(ctl_q.watchdog_change_enable_bit));
    pin_reset_c: cover property ($fell(chip_rst_q) && cause_q.pin_reset_flag);

endmodule

// ===== bench/rwc_core_model.sv
`timescale 1ns/1ns

// Processor core side: issues watchdog restarts while it runs
module rwc_core_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic chip_rst_i,
    input  wire logic run_i,
    input  wire logic slow_i,
    output logic      restart_o
);
    logic [7:0] gap_q;

    // Slow mode restarts too late on purpose, so the watchdog bites
    always_ff @(posedge clk_i) begin
        if (rst_i || chip_rst_i || !run_i) begin
            gap_q     <= 8'h00;
            restart_o <= 1'b0;
        end else begin
            gap_q     <= (gap_q == (slow_i ? 8'hC8 : 8'h14)) ? 8'h00 : gap_q + 8'h01;
            restart_o <= (gap_q == 8'h00);
        end
    end
endmodule

// ===== bench/tb_reset_watchdog_controller.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb_reset_watchdog_controller;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ext_n = 1'b1;
    logic        por   = 1'b0;
    logic        brownout_detector   = 1'b0;
    logic        tap   = 1'b0;
    logic        osc   = 1'b0;
    logic        aon   = 1'b0;
    logic        boden = 1'b0;
    logic        run   = 1'b0;
    logic        slow  = 1'b0;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] adr   = 32'h0000_0000;
    logic [31:0] dat   = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack, chip_rst, expire, vref, restart;
    int          n_fail = 0;
    int          checks_done = 0;
    int          cyc_n = 0;
    int          n;

    always #5 clk_i = ~clk_i;

    // Osc at clk/16; the cycle count doubles as the hang guard
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        osc   <= cyc_n[3];
        if (cyc_n == 40000) begin
            n_fail++;
            results();
        end
    end

    rwc_reset_watchdog #(.WDT_BASE(22'h00_0004)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .ext_rst_n_i(ext_n), .por_i(por), .bod_low_i(brownout_detector),
        .tap_rst_i(tap), .wdt_osc_i(osc), .wdt_always_on_i(aon), .bod_enable_i(boden),
        .timeout_cycles_i(16'h0008), .wdt_restart_i(restart), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .chip_rst_o(chip_rst), .wdt_expire_o(expire), .vref_on_o(vref));

    rwc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .chip_rst_i(chip_rst), .run_i(run),
        .slow_i(slow), .restart_o(restart));

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        sel <= 4'hF;
        adr <= {24'h00_0000, a};
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0000_0000, q);
        `CHK(q, e)
    endtask

    task automatic ticks(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    task automatic wait_exp(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (expire !== 1'b1);
    endtask

    // Stretch must last the programmed delay plus sync latency
    task automatic settle(input logic [31:0] cause);
        int k;
        k = 0;
        while (chip_rst !== 1'b0) begin
            @(posedge clk_i);
            k++;
        end
        `CHK(k >= 7 && k <= 24, 1'b1)
        rd(8'h04, cause);
    endtask

    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        ticks(10);
        rst_i <= 1'b0;
        ticks(30);
        `CHK(chip_rst, 1'b0)
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        rd(8'h08, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
        @(posedge clk_i);
        ext_n <= 1'b0;
        #1 `CHK(chip_rst, 1'b1)
        ticks(10);
        ext_n <= 1'b1;
        settle(32'h0000_0002);
        @(posedge clk_i);
        por <= 1'b1;
        #1 `CHK(chip_rst, 1'b1)
        ticks(10);
        por <= 1'b0;
        settle(32'h0000_0001);
        wr(8'h04, 32'h0000_0000);
        rd(8'h04, 32'h0000_0000);
        tap <= 1'b1;
        ticks(60);
        `CHK(chip_rst, 1'b1)
        tap <= 1'b0;
        settle(32'h0000_0010);
        wr(8'h04, 32'h0000_0000);
        for (int m = 1; m < 4; m++) begin
            wr(8'h08, {30'h0, m[1:0]});
            ticks(2);
            `CHK(vref, 1'b1)
        end
        wr(8'h08, 32'h0000_0000);
        ticks(2);
        `CHK(vref, 1'b0)
        boden <= 1'b1;
        brownout_detector   <= 1'b1;
        ticks(100);
        `CHK(chip_rst, 1'b0)
        brownout_detector <= 1'b0;
        ticks(10);
        `CHK(vref, 1'b1)
        brownout_detector <= 1'b1;
        ticks(260);
        `CHK(chip_rst, 1'b1)
        brownout_detector <= 1'b0;
        settle(32'h0000_0004);
        boden <= 1'b0;
        for (int p = 0; p < 8; p++) begin
            wr(8'h04, 32'h0000_0000);
            wr(8'h00, 32'h0000_0018);
            wr(8'h00, {29'h0, p[2:0]} | 32'h0000_0008);
            wait_exp(n);
            `CHK(n >= (64 << p) - 20 && n <= (64 << p) + 48, 1'b1)
            @(posedge clk_i);
            `CHK({expire, chip_rst}, 2'b01)
            settle(32'h0000_0008);
            rd(8'h00, 32'h0000_0000);
        end
        run <= 1'b1;
        wr(8'h00, 32'h0000_0008);
        ticks(400);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0018);
        ticks(6);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0018);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0000);
        wr(8'h00, 32'h0000_0008);
        slow <= 1'b1;
        wait_exp(n);
        `CHK(n <= 120, 1'b1)
        slow <= 1'b0;
        @(posedge clk_i);
        `CHK({expire, chip_rst}, 2'b01)
        settle(32'h0000_0008);
        aon   <= 1'b1;
        rst_i <= 1'b1;
        ticks(10);
        rst_i <= 1'b0;
        ticks(30);
        rd(8'h00, 32'h0000_0008);
        wr(8'h00, 32'h0000_0018);
        wr(8'h00, 32'h0000_0003);
        rd(8'h00, 32'h0000_000B);
        wr(8'h00, 32'h0000_0018);
        wr(8'h00, 32'h0000_0000);
        rd(8'h00, 32'h0000_0008);
        run <= 1'b0;
        wait_exp(n);
        `CHK(n <= 120, 1'b1)
        results();
    end
endmodule
